/* File: i2c_mt_pkg.sv */
// Purpose: Shared constants for the two-wire master transmitter sequencer.
// Assumes: 32-bit APB register words at byte offsets; 25 MHz system clock.
// Notes:   Status codes carry zero prescaler bits.
package i2c_mt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STAT     = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_BITRATE  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Control register bit positions
  localparam int CB_DONE  = 7;
  localparam int CB_ACKEN = 6;
  localparam int CB_START = 5;
  localparam int CB_STOP  = 4;
  localparam int CB_WCOL  = 3;
  localparam int CB_EN    = 2;
  // Interrupt status and mask bit positions
  localparam int IB_DONE = 0;
  localparam int IB_WCOL = 1;
  localparam int IB_ARB  = 2;
  localparam int IRQ_W   = 3;
  // Status codes
  localparam logic [7:0] SC_START     = 8'h08;
  localparam logic [7:0] SC_RSTART    = 8'h10;
  localparam logic [7:0] SC_SLAW_ACK  = 8'h18;
  localparam logic [7:0] SC_SLAW_NACK = 8'h20;
  localparam logic [7:0] SC_DATA_ACK  = 8'h28;
  localparam logic [7:0] SC_DATA_NACK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST  = 8'h38;
  localparam logic [7:0] SC_SLAR_ACK  = 8'h40;
  localparam logic [7:0] SC_SLAR_NACK = 8'h48;
  localparam logic [7:0] SC_MASK      = 8'hF8;
  // Reset values
  localparam logic [7:0] STAT_RST = 8'hF8;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] MASK_RST = 8'h00;
  // Timing: one quarter of a bus bit period
  localparam int CLK_NS  = 40;
  localparam int QTR_NS  = 2500;
  localparam int QTR_CYC = QTR_NS / CLK_NS;
  // Bus sequencer states, one-hot
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_FREE  = 6'b000010,
    S_START = 6'b000100,
    S_BYTE  = 6'b001000,
    S_STOP  = 6'b010000,
    S_HOLD  = 6'b100000
  } seq_state_t;
endpackage

/* File: i2c_master_transmit_sequencer.sv */
// Purpose: Two-wire bus master transmitter driven by software over APB.
// Assumes: Open-drain pins resolved outside; pin inputs are asynchronous.
// Notes:   Bus is held with the clock line low while the step-done flag is set, except after lost arbitration or once the enable bit is cleared.
// Behaviour
// - START from idle or after STOP is generated only once the bus has been seen free.
// - After START the done flag sets and status reads 0x08.
// - Address write bit keeps transmit mode; read bit selects receive mode.
// - After address plus write, status 0x18 ack, 0x20 nack, 0x38 lost.
// - Data write with done low is dropped and sets write collision.
// - Repeated START reports 0x10 and the bus stays owned.
// - At 0x10, write address stays transmit; read address switches to receive.
// - Resume with no start or stop sends data; start alone sends repeated START.
// - Resume with stop alone sends STOP and hardware clears the stop bit.
// - Resume with start and stop sends STOP, clears stop, then START.
// - After a data byte, status 0x28 on ack and 0x30 on nack.
// - Lost arbitration reports 0x38 and releases the bus; resume with start retries START when free.
// - Status code occupies the upper five bits; prescaler bits sit below.
// - While done is set after START or a byte and the enable bit stays set, the transfer stays suspended, holding the bus.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module i2c_master_transmit_sequencer #(
  parameter int QTR_RST = i2c_mt_pkg::QTR_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_b_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_b_out,
  output logic             master_transmit_mode_out,
  output logic             master_receive_mode_out,
  output logic             irq_out
);
  // Phase two stretches until the synchronised clock is high, so one cycle is enough
  if (QTR_RST < 1 || QTR_RST > 255) begin : g_chk
    $error("QTR_RST must lie in 1..255");
  end

  // Pin synchronisers and delayed copies for edge finding
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r, sda_d_r, scl_d_r, busy_r, busy_nxt;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      scl_d_r <= 1'b1;
      busy_r  <= 1'b0;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      scl_d_r <= scl_s_r;
      busy_r  <= busy_nxt;
    end
  end

  // Bus busy between any START and STOP seen on the lines
  always_comb begin
    busy_nxt = busy_r;
    if (scl_s_r && scl_d_r && sda_d_r && !sda_s_r) busy_nxt = 1'b1;
    if (scl_s_r && scl_d_r && !sda_d_r && sda_s_r) busy_nxt = 1'b0;
  end

  // APB decode
  logic setup, wr, wr_ctrl, wr_data, go, hit;
  assign setup   = psel_in && !penable_in;
  assign wr      = psel_in && penable_in && pwrite_in;
  assign wr_ctrl = wr && paddr_in == i2c_mt_pkg::OFS_CTRL;
  assign wr_data = wr && paddr_in == i2c_mt_pkg::OFS_DATA;
  assign go      = wr_ctrl && pwdata_in[i2c_mt_pkg::CB_DONE] && pwdata_in[i2c_mt_pkg::CB_EN];
  assign pready_out = psel_in && penable_in;
  assign hit = paddr_in == i2c_mt_pkg::OFS_CTRL || paddr_in == i2c_mt_pkg::OFS_STAT
            || paddr_in == i2c_mt_pkg::OFS_DATA || paddr_in == i2c_mt_pkg::OFS_BITRATE
            || paddr_in == i2c_mt_pkg::OFS_IRQ_STAT || paddr_in == i2c_mt_pkg::OFS_IRQ_MASK;

  // Software-visible registers
  logic       done_r, done_nxt, start_r, start_nxt, stop_r, stop_nxt;
  logic       en_r, en_nxt, acken_r, acken_nxt, wcol_r, wcol_nxt, err_r, err_nxt;
  logic [7:0] code_r, code_nxt, data_r, data_nxt, brate_r, brate_nxt;
  logic [1:0] presc_r, presc_nxt;
  logic [2:0] istat_r, istat_nxt, imask_r, imask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic       hw_set, hw_stop_clr, arb_ev;
  logic [7:0] hw_code;

  always_comb begin
    done_nxt  = hw_set || (done_r && !go);
    start_nxt = wr_ctrl ? pwdata_in[i2c_mt_pkg::CB_START] : start_r;
    stop_nxt  = wr_ctrl ? pwdata_in[i2c_mt_pkg::CB_STOP] : (stop_r && !hw_stop_clr);
    en_nxt    = wr_ctrl ? pwdata_in[i2c_mt_pkg::CB_EN] : en_r;
    acken_nxt = wr_ctrl ? pwdata_in[i2c_mt_pkg::CB_ACKEN] : acken_r;
    wcol_nxt  = wr_data ? !done_r : wcol_r;
    data_nxt  = (wr_data && done_r) ? pwdata_in[7:0] : data_r;
    code_nxt  = hw_set ? hw_code : code_r;
    presc_nxt = (wr && paddr_in == i2c_mt_pkg::OFS_STAT) ? pwdata_in[1:0] : presc_r;
    brate_nxt = (wr && paddr_in == i2c_mt_pkg::OFS_BITRATE) ? pwdata_in[7:0] : brate_r;
    imask_nxt = (wr && paddr_in == i2c_mt_pkg::OFS_IRQ_MASK) ? pwdata_in[2:0] : imask_r;
    istat_nxt = istat_r;
    if (wr && paddr_in == i2c_mt_pkg::OFS_IRQ_STAT) istat_nxt = istat_r & ~pwdata_in[2:0];
    istat_nxt[i2c_mt_pkg::IB_DONE] = istat_nxt[i2c_mt_pkg::IB_DONE] | hw_set;
    istat_nxt[i2c_mt_pkg::IB_WCOL] = istat_nxt[i2c_mt_pkg::IB_WCOL] | (wr_data && !done_r);
    istat_nxt[i2c_mt_pkg::IB_ARB]  = istat_nxt[i2c_mt_pkg::IB_ARB] | arb_ev;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      err_nxt = !hit;
      case (paddr_in)
        i2c_mt_pkg::OFS_CTRL:     rdata_nxt = {24'h00_0000, done_r, acken_r, start_r,
                                               stop_r, wcol_r, en_r, 2'b00};
        i2c_mt_pkg::OFS_STAT:     rdata_nxt = {24'h00_0000, code_r[7:3], 1'b0, presc_r};
        i2c_mt_pkg::OFS_DATA:     rdata_nxt = {24'h00_0000, data_r};
        i2c_mt_pkg::OFS_BITRATE:  rdata_nxt = {24'h00_0000, brate_r};
        i2c_mt_pkg::OFS_IRQ_STAT: rdata_nxt = {29'h0000_0000, istat_r};
        i2c_mt_pkg::OFS_IRQ_MASK: rdata_nxt = {29'h0000_0000, imask_r};
        default:                  rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_r  <= 1'b0;
      start_r <= 1'b0;
      stop_r  <= 1'b0;
      en_r    <= 1'b0;
      acken_r <= 1'b0;
      wcol_r  <= 1'b0;
      err_r   <= 1'b0;
      code_r  <= i2c_mt_pkg::STAT_RST;
      data_r  <= i2c_mt_pkg::DATA_RST;
      presc_r <= 2'b00;
      brate_r <= 8'(QTR_RST);
      istat_r <= 3'b000;
      imask_r <= i2c_mt_pkg::MASK_RST[2:0];
      rdata_r <= 32'h0000_0000;
    end else begin
      done_r  <= done_nxt;
      start_r <= start_nxt;
      stop_r  <= stop_nxt;
      en_r    <= en_nxt;
      acken_r <= acken_nxt;
      wcol_r  <= wcol_nxt;
      err_r   <= err_nxt;
      code_r  <= code_nxt;
      data_r  <= data_nxt;
      presc_r <= presc_nxt;
      brate_r <= brate_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata_out  = rdata_r;
  assign pslverr_out = pready_out && err_r;
  assign irq_out     = |(istat_r & imask_r);

  // Bus sequencer state
  i2c_mt_pkg::seq_state_t st_r, st_nxt;
  logic [1:0]  ph_r, ph_nxt;
  logic [15:0] cnt_r, cnt_nxt, qtr;
  logic [3:0]  bit_r, bit_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        scl_rel_r, scl_rel_nxt, sda_rel_r, sda_rel_nxt;
  logic        own_r, own_nxt, adr_r, adr_nxt, rw_r, rw_nxt, ack_r, ack_nxt, rx_r, rx_nxt;
  logic        tick, adv;

  // Quarter period scaled by the prescaler, four times per step
  assign qtr  = 16'({8'h00, brate_r} << {presc_r, 1'b0});
  assign tick = cnt_r == 16'h0000;
  assign adv  = tick && (ph_r != 2'd2 || scl_s_r);

  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    cnt_nxt = tick ? qtr : 16'(cnt_r - 16'h0001);
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    scl_rel_nxt = scl_rel_r;
    sda_rel_nxt = sda_rel_r;
    own_nxt = own_r;
    adr_nxt = adr_r;
    rw_nxt = rw_r;
    ack_nxt = ack_r;
    rx_nxt = rx_r;
    hw_set = 1'b0;
    hw_code = code_r;
    hw_stop_clr = 1'b0;
    arb_ev = 1'b0;
    case (st_r)
      i2c_mt_pkg::S_IDLE: begin
        scl_rel_nxt = 1'b1;
        sda_rel_nxt = 1'b1;
        own_nxt = 1'b0;
        rx_nxt = 1'b0;
        if (go && pwdata_in[i2c_mt_pkg::CB_START]) st_nxt = i2c_mt_pkg::S_FREE;
      end
      i2c_mt_pkg::S_FREE: begin
        if (!busy_r) begin
          st_nxt = i2c_mt_pkg::S_START;
          ph_nxt = 2'd0;
          cnt_nxt = qtr;
        end
      end
      i2c_mt_pkg::S_START: begin
        if (adv) begin
          ph_nxt = 2'(ph_r + 2'd1);
          case (ph_r)
            2'd0: sda_rel_nxt = 1'b1;
            2'd1: scl_rel_nxt = 1'b1;
            2'd2: sda_rel_nxt = 1'b0;
            default: begin
              scl_rel_nxt = 1'b0;
              hw_set = 1'b1;
              hw_code = own_r ? i2c_mt_pkg::SC_RSTART : i2c_mt_pkg::SC_START;
              own_nxt = 1'b1;
              adr_nxt = 1'b1;
              rx_nxt = 1'b0;
              st_nxt = i2c_mt_pkg::S_HOLD;
            end
          endcase
        end
      end
      i2c_mt_pkg::S_BYTE: begin
        if (adv) begin
          ph_nxt = 2'(ph_r + 2'd1);
          case (ph_r)
            2'd0: sda_rel_nxt = (bit_r == 4'd8) ? 1'b1 : sh_r[7];
            2'd1: scl_rel_nxt = 1'b1;
            2'd2: begin
              if (bit_r != 4'd8 && sda_rel_r && !sda_s_r) begin
                scl_rel_nxt = 1'b1;
                hw_set = 1'b1;
                hw_code = i2c_mt_pkg::SC_ARB_LOST;
                arb_ev = 1'b1;
                own_nxt = 1'b0;
                st_nxt = i2c_mt_pkg::S_IDLE;
              end
              ack_nxt = !sda_s_r;
            end
            default: begin
              scl_rel_nxt = 1'b0;
              sh_nxt = {sh_r[6:0], 1'b0};
              bit_nxt = 4'(bit_r + 4'd1);
              if (bit_r == 4'd8) begin
                hw_set = 1'b1;
                st_nxt = i2c_mt_pkg::S_HOLD;
                adr_nxt = 1'b0;
                rx_nxt = adr_r && rw_r;
                if (adr_r && rw_r)
                  hw_code = ack_r ? i2c_mt_pkg::SC_SLAR_ACK : i2c_mt_pkg::SC_SLAR_NACK;
                else if (adr_r)
                  hw_code = ack_r ? i2c_mt_pkg::SC_SLAW_ACK : i2c_mt_pkg::SC_SLAW_NACK;
                else
                  hw_code = ack_r ? i2c_mt_pkg::SC_DATA_ACK : i2c_mt_pkg::SC_DATA_NACK;
              end
            end
          endcase
        end
      end
      i2c_mt_pkg::S_STOP: begin
        if (adv) begin
          ph_nxt = 2'(ph_r + 2'd1);
          case (ph_r)
            2'd0: sda_rel_nxt = 1'b0;
            2'd1: scl_rel_nxt = 1'b1;
            2'd2: sda_rel_nxt = 1'b1;
            default: begin
              hw_stop_clr = 1'b1;
              own_nxt = 1'b0;
              rx_nxt = 1'b0;
              st_nxt = start_r ? i2c_mt_pkg::S_FREE : i2c_mt_pkg::S_IDLE;
            end
          endcase
        end
      end
      i2c_mt_pkg::S_HOLD: begin
        scl_rel_nxt = 1'b0;
        if (go) begin
          ph_nxt = 2'd0;
          cnt_nxt = qtr;
          if (pwdata_in[i2c_mt_pkg::CB_STOP]) st_nxt = i2c_mt_pkg::S_STOP;
          else if (pwdata_in[i2c_mt_pkg::CB_START]) st_nxt = i2c_mt_pkg::S_START;
          else begin
            st_nxt = i2c_mt_pkg::S_BYTE;
            bit_nxt = 4'd0;
            sh_nxt = data_r;
            rw_nxt = adr_r && data_r[0];
          end
        end
      end
      default: st_nxt = i2c_mt_pkg::S_IDLE;
    endcase
    // Abort on the value being written, so one write may both enable and start
    if (!en_nxt) begin
      st_nxt = i2c_mt_pkg::S_IDLE;
      scl_rel_nxt = 1'b1;
      sda_rel_nxt = 1'b1;
      own_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r      <= i2c_mt_pkg::S_IDLE;
      ph_r      <= 2'd0;
      cnt_r     <= 16'h0000;
      bit_r     <= 4'd0;
      sh_r      <= 8'h00;
      scl_rel_r <= 1'b1;
      sda_rel_r <= 1'b1;
      own_r     <= 1'b0;
      adr_r     <= 1'b0;
      rw_r      <= 1'b0;
      ack_r     <= 1'b0;
      rx_r      <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      ph_r      <= ph_nxt;
      cnt_r     <= cnt_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      scl_rel_r <= scl_rel_nxt;
      sda_rel_r <= sda_rel_nxt;
      own_r     <= own_nxt;
      adr_r     <= adr_nxt;
      rw_r      <= rw_nxt;
      ack_r     <= ack_nxt;
      rx_r      <= rx_nxt;
    end
  end

  // Open-drain pins: output enable low pulls the line low
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe_b_out = scl_rel_r;
  assign sda_oe_b_out = sda_rel_r;
  assign master_receive_mode_out  = rx_r;
  assign master_transmit_mode_out = own_r && !rx_r;

  // Checks
  sequence stop_done_s;
    hw_stop_clr && start_r;
  endsequence
  sequence restart_s;
    !stop_r && st_r == i2c_mt_pkg::S_FREE;
  endsequence

  start_code_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_r == i2c_mt_pkg::S_START && st_nxt == i2c_mt_pkg::S_HOLD && !own_r)
    |=> done_r && code_r == 8'h08)
    else $error("START did not report 0x08");
  free_wait_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_r == i2c_mt_pkg::S_FREE && busy_r) |=> st_r != i2c_mt_pkg::S_START)
    else $error("START issued on busy bus");
  wcol_drop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_data && !done_r) |=> wcol_r && data_r == $past(data_r))
    else $error("Collided data write not dropped");
  hold_bus_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_r == i2c_mt_pkg::S_HOLD && done_r && !go) |=> !scl_oe_b_out && st_r == i2c_mt_pkg::S_HOLD)
    else $error("Bus not held while done set");
  stop_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (hw_stop_clr && !wr_ctrl) |=> !stop_r && sda_oe_b_out)
    else $error("Stop bit not cleared after STOP");
  stop_start_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    stop_done_s |=> restart_s)
    else $error("STOP then START did not follow");
  done_zero_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (done_r && !go) |=> done_r)
    else $error("Done flag lost without a one written");
  arb_lost_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    arb_ev |=> code_r == 8'h38 && done_r && st_r == i2c_mt_pkg::S_IDLE && scl_oe_b_out)
    else $error("Lost arbitration not reported");
  data_code_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (st_r == i2c_mt_pkg::S_BYTE && bit_r == 4'd8 && ph_r == 2'd3 && adv && !adr_r)
    |=> code_r == (ack_r ? 8'h28 : 8'h30) ##1 st_r == i2c_mt_pkg::S_HOLD)
    else $error("Data byte status wrong");
endmodule

/* File: i2c_slave_model.sv */
// Purpose: Behavioural slave receiver on the two-wire bus.
// Assumes: Wire levels are resolved with pull-ups; the clock is never stretched.
// Notes:   Acknowledges each byte while ack_en_in is high; counts starts and stops.
`timescale 1ns/1ps
module i2c_slave_model (
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  input  wire logic  ack_en_in,
  output logic       sda_pull_out,
  output logic [7:0] byte_out,
  output int         starts_out,
  output int         stops_out
);
  logic [7:0] shift_r;
  int         bit_cnt;
  logic       acking;
  // Idle: line released, nothing received
  initial begin
    sda_pull_out = 1'b0;
    byte_out     = 8'h00;
    shift_r      = 8'h00;
    starts_out   = 0;
    stops_out    = 0;
    bit_cnt      = 0;
    acking       = 1'b0;
  end
  // Framing: data falling with clock high starts, data rising stops
  always @(sda_in) begin
    if (scl_in === 1'b1) begin
      if (sda_in === 1'b0) starts_out++;
      else stops_out++;
      bit_cnt      = 0;
      acking       = 1'b0;
      sda_pull_out = 1'b0;
    end
  end
  // Data bits are taken most significant first on the rising clock
  always @(posedge scl_in) begin
    if (bit_cnt < 8) begin
      shift_r = {shift_r[6:0], sda_in};
      bit_cnt++;
    end
  end
  // Acknowledge is driven over the ninth clock, then the line is let go
  always @(negedge scl_in) begin
    if (acking) begin
      sda_pull_out = 1'b0;
      acking       = 1'b0;
      bit_cnt      = 0;
    end else if (bit_cnt == 8) begin
      byte_out     = shift_r;
      sda_pull_out = ack_en_in;
      acking       = 1'b1;
    end
  end
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the two-wire master transmitter sequencer.
// Assumes: Quarter period of one cycle gives a 400 ns bus bit.
// Notes:   Reads are compared by a monitor against queued expectations.
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [31:0] v; logic [31:0] m;} exp_t;
  localparam logic [31:0] GO_START = 32'h0000_00A4;
  localparam logic [31:0] GO_CONT  = 32'h0000_0084;
  localparam logic [31:0] GO_STOP  = 32'h0000_0094;
  localparam logic [31:0] GO_BOTH  = 32'h0000_00B4;
  logic        clk_in, rst_b_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [7:0]  paddr_in, slv_byte, addr;
  logic [31:0] pwdata_in, prdata_out, q;
  logic        scl_out, sda_out, scl_oe_b_out, sda_oe_b_out, mt_mode, mr_mode, irq_out;
  logic        slv_pull, arb_pull, ack_en, scl_w, sda_w;
  int          fail_count, num_checks, slv_starts, slv_stops, n0;
  exp_t        exp_q[$];
  exp_t        e;
  // Open-drain wires with pull-ups
  assign scl_w = scl_oe_b_out;
  assign sda_w = sda_oe_b_out & ~slv_pull & ~arb_pull;
  i2c_master_transmit_sequencer #(.QTR_RST(1)) i_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_b_out(scl_oe_b_out), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_b_out(sda_oe_b_out), .master_transmit_mode_out(mt_mode),
    .master_receive_mode_out(mr_mode), .irq_out(irq_out));
  i2c_slave_model i_slave (
    .scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en), .sda_pull_out(slv_pull),
    .byte_out(slv_byte), .starts_out(slv_starts), .stops_out(slv_stops));
  // 25 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One APB transfer; a read queues its expected value under a compare mask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    int n;
    if (!wr) exp_q.push_back('{d, m});
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= wr ? d : 32'($urandom);
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      end_of_test();
    end
    q = prdata_out;
    check(32'(pslverr_out), 32'(a > 8'h14), "slave error");
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic go(input logic [31:0] c);
    apb(1'b1, i2c_mt_pkg::OFS_CTRL, c | (32'($urandom) & 32'h0000_0040), '0);
  endtask
  task automatic code(input logic [7:0] c);
    apb(1'b0, i2c_mt_pkg::OFS_STAT, {24'h0, c}, {24'h0, i2c_mt_pkg::SC_MASK});
  endtask
  // Polls a control bit under a bounded count
  task automatic wait_ctrl(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, i2c_mt_pkg::OFS_CTRL, '0, '0);
      n++;
    end while (q[b] !== v && n < 400);
    if (n >= 400) begin
      fail_count++;
      end_of_test();
    end
  endtask
  // Loads a byte, resumes, and checks status, wire byte and held clock
  task automatic send(input logic [7:0] b, input logic ak, input logic [7:0] c);
    ack_en <= ak;
    apb(1'b1, i2c_mt_pkg::OFS_DATA, {24'h0, b}, '0);
    go(GO_CONT);
    wait_ctrl(i2c_mt_pkg::CB_DONE, 1'b1);
    code(c);
    check(32'(slv_byte), 32'(b), "byte on wire");
    check(32'(scl_w), 32'h0, "clock held low");
  endtask
  // Compares each read with a nonzero mask against the oldest queued expectation
  always @(posedge clk_in) begin
    if (psel_in && penable_in && !pwrite_in && pready_out === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.m != '0) check(prdata_out & e.m, e.v, "read data");
    end
  end
  // Main sequence
  initial begin
    {psel_in, penable_in, pwrite_in, arb_pull, rst_b_in} = '0;
    paddr_in   = 8'h00;
    pwdata_in  = 32'h0000_0000;
    ack_en     = 1'b1;
    fail_count = 0;
    num_checks = 0;
    void'($urandom(32'hde6f));
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    check(32'({scl_out, sda_out}), 32'h0, "pins drive low");
    apb(1'b0, i2c_mt_pkg::OFS_STAT, 32'h0000_00F8, 32'h0000_00FF);
    // Prescaler bits read back but vanish under the status mask
    apb(1'b1, i2c_mt_pkg::OFS_STAT, 32'h0000_0003, '0);
    apb(1'b0, i2c_mt_pkg::OFS_STAT, 32'h0000_00FB, 32'h0000_00FF);
    apb(1'b0, i2c_mt_pkg::OFS_STAT, 32'h0000_00F8, {24'h0, i2c_mt_pkg::SC_MASK});
    apb(1'b1, i2c_mt_pkg::OFS_STAT, 32'h0000_0000, '0);
    apb(1'b0, i2c_mt_pkg::OFS_DATA, 32'h0000_00FF, '1);
    apb(1'b0, i2c_mt_pkg::OFS_BITRATE, 32'h0000_0001, '1);
    apb(1'b0, 8'h18, '0, '1);
    apb(1'b1, i2c_mt_pkg::OFS_IRQ_MASK, 32'h0000_0007, '0);
    // Data write with the flag low is dropped and flagged
    apb(1'b1, i2c_mt_pkg::OFS_DATA, 32'h0000_005A, '0);
    apb(1'b0, i2c_mt_pkg::OFS_DATA, 32'h0000_00FF, '1);
    apb(1'b0, i2c_mt_pkg::OFS_CTRL, 32'h0000_0008, 32'h0000_0008);
    check(32'(irq_out), 32'h1, "collision interrupt");
    apb(1'b1, i2c_mt_pkg::OFS_IRQ_STAT, 32'h0000_0002, '0);
    check(32'(irq_out), 32'h0, "interrupt cleared");
    // START waits while a foreign master holds the bus
    arb_pull <= 1'b1;
    @(posedge clk_in);
    go(GO_START);
    repeat (100) @(posedge clk_in);
    check(32'({scl_oe_b_out, sda_oe_b_out}), 32'h3, "start while busy");
    arb_pull <= 1'b0;
    wait_ctrl(i2c_mt_pkg::CB_DONE, 1'b1);
    code(i2c_mt_pkg::SC_START);
    apb(1'b1, i2c_mt_pkg::OFS_CTRL, 32'h0000_0004, '0);
    apb(1'b0, i2c_mt_pkg::OFS_CTRL, 32'h0000_0080, 32'h0000_0080);
    addr = {7'($urandom), 1'b0};
    send(addr, 1'b1, i2c_mt_pkg::SC_SLAW_ACK);
    check(32'(mt_mode), 32'h1, "transmit mode");
    check(32'(irq_out), 32'h1, "done interrupt");
    apb(1'b1, i2c_mt_pkg::OFS_IRQ_MASK, 32'h0000_0000, '0);
    check(32'(irq_out), 32'h0, "interrupt masked");
    apb(1'b1, i2c_mt_pkg::OFS_IRQ_STAT, 32'h0000_0007, '0);
    apb(1'b1, i2c_mt_pkg::OFS_IRQ_MASK, 32'h0000_0007, '0);
    check(32'(irq_out), 32'h0, "status cleared");
    for (int i = 0; i < 3; i++) begin
      send(8'($urandom), i != 1, (i != 1) ? i2c_mt_pkg::SC_DATA_ACK : i2c_mt_pkg::SC_DATA_NACK);
    end
    // STOP followed by START
    n0 = slv_stops;
    go(GO_BOTH);
    wait_ctrl(i2c_mt_pkg::CB_DONE, 1'b1);
    code(i2c_mt_pkg::SC_START);
    check(32'(slv_stops - n0), 32'h1, "stop before start");
    apb(1'b0, i2c_mt_pkg::OFS_CTRL, '0, 32'h0000_0010);
    send(addr, 1'b0, i2c_mt_pkg::SC_SLAW_NACK);
    // Repeated START, then address with read
    n0 = slv_starts;
    go(GO_START);
    wait_ctrl(i2c_mt_pkg::CB_DONE, 1'b1);
    code(i2c_mt_pkg::SC_RSTART);
    check(32'(slv_starts - n0), 32'h1, "repeated start");
    send(addr | 8'h01, 1'b1, i2c_mt_pkg::SC_SLAR_ACK);
    check(32'(mr_mode), 32'h1, "receive mode");
    n0 = slv_stops;
    go(GO_STOP);
    wait_ctrl(i2c_mt_pkg::CB_STOP, 1'b0);
    check(32'(slv_stops - n0), 32'h1, "stop sent");
    // Lost arbitration on a transmitted one
    ack_en <= 1'b0;
    go(GO_START);
    wait_ctrl(i2c_mt_pkg::CB_DONE, 1'b1);
    apb(1'b1, i2c_mt_pkg::OFS_DATA, 32'h0000_00A0, '0);
    arb_pull <= 1'b1;
    go(GO_CONT);
    wait_ctrl(i2c_mt_pkg::CB_DONE, 1'b1);
    code(i2c_mt_pkg::SC_ARB_LOST);
    apb(1'b0, i2c_mt_pkg::OFS_IRQ_STAT, 32'h0000_0004, 32'h0000_0004);
    go(GO_CONT);
    repeat (20) @(posedge clk_in);
    check(32'({scl_oe_b_out, sda_oe_b_out, mt_mode}), 32'h6, "bus released");
    arb_pull <= 1'b0;
    @(posedge clk_in);
    end_of_test();
  end
endmodule
